// ==== core/pfc_carriage.sv ====
`timescale 1ns/100ps
module pfc_carriage
  import pfc_pkg::*;
#(
  parameter int unsigned LINES = PFC_LINES,
  parameter bit EXT_POSITIONS = 1'b0
) (
  input wire logic i_mclk, // System clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_req_valid, // Command offered
  input wire pfc_req_t i_req, // Command fields
  output logic o_req_ready, // Command taken when high
  input wire logic i_load_valid, // Spacing image entry valid
  input wire pfc_entry_t i_load_entry, // Spacing image entry
  input wire logic i_load_last, // Last image entry
  output logic o_load_ready, // Image entry accepted
  input wire logic i_plb_parity_err, // Print line buffer parity fault
  input wire logic i_plb_fault, // Other control unit malfunction
  input wire logic i_sense_clear, // Clear sense and resume motion
  output logic o_form_step, // One-line carriage advance pulse
  output logic o_eight_lpi, // Spacing density flag
  output logic [7:0] o_line_addr, // Current line address
  output logic o_busy, // Command in progress
  output logic o_done, // Command completion pulse
  output logic [8*PFC_SENSE_BYTES-1:0] o_sense, // Sense bytes
  output logic [7:0] o_print_positions // Print line width
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {PFC_IDLE, PFC_MOVE, PFC_LOADING} pfc_state_t;

  pfc_entry_t spacing_mem [LINES];
  pfc_state_t state_q;
  logic [7:0] addr_q;
  logic [7:0] remain_q;
  logic [3:0] target_q;
  logic is_skip_q;
  logic [1:0] home_seen_q;
  logic [7:0] load_idx_q;
  logic load_eof_q;
  logic load_bad_q;
  logic eight_lpi_q;
  logic [7:0] last_line_q;
  logic hold_q;
  logic [7:0] sense_q [PFC_SENSE_BYTES];
  logic step;
  logic [7:0] next_addr;
  logic bad_code;
  logic runaway;
  logic hit;

  // Stop code legal when zero (none) or 1..12
  function automatic logic pfc_code_bad(input logic [3:0] c);
    pfc_code_bad = (c != 4'h0) && ((c < PFC_CODE_MIN) || (c > PFC_CODE_MAX));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Wrap after end-of-form line or last entry
  assign next_addr = (addr_q == last_line_q) ? PFC_FIRST_LINE : addr_q + 8'h01;
  // Motion is frozen while a retryable error is pending
  assign step = (state_q == PFC_MOVE) && !hold_q;
  assign hit = (spacing_mem[next_addr].stop_code == target_q);
  // Second pass over line one ends a skip for a missing code
  assign runaway = is_skip_q && (next_addr == PFC_FIRST_LINE) && (home_seen_q == 2'h1);
  assign bad_code = pfc_pkg_bad_wrap(i_load_entry.stop_code);
  function automatic logic pfc_pkg_bad_wrap(input logic [3:0] c);
    pfc_pkg_bad_wrap = pfc_code_bad(c);
  endfunction

  assign o_req_ready = (state_q == PFC_IDLE);
  assign o_load_ready = (state_q == PFC_LOADING);
  assign o_busy = (state_q != PFC_IDLE);
  assign o_line_addr = addr_q;
  assign o_eight_lpi = eight_lpi_q;
  assign o_print_positions = EXT_POSITIONS ? 8'(PFC_POS_EXT) : 8'(PFC_POS_STD);

  //////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= PFC_IDLE;
      remain_q <= 8'h00;
      target_q <= 4'h0;
      is_skip_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_q)
        PFC_IDLE: begin
          if (i_req_valid) begin
            target_q <= i_req.code;
            remain_q <= i_req.count;
            is_skip_q <= (i_req.op == PFC_CMD_SKIP);
            if (i_req.op == PFC_CMD_LOAD) begin
              state_q <= PFC_LOADING;
            end else if (i_req.op == PFC_CMD_SKIP || i_req.count != 8'h00) begin
              state_q <= PFC_MOVE;
            end else begin
              o_done <= 1'b1;
            end
          end
        end
        PFC_MOVE: begin
          if (step) begin
            remain_q <= remain_q - 8'h01;
            if ((is_skip_q && (hit || runaway)) || (!is_skip_q && remain_q == 8'h01)) begin
              state_q <= PFC_IDLE;
              o_done <= 1'b1;
            end
          end
        end
        PFC_LOADING: begin
          if (i_load_valid && (i_load_last || load_idx_q == 8'(LINES - 1))) begin
            state_q <= PFC_IDLE;
            o_done <= 1'b1;
          end
        end
        default: state_q <= PFC_IDLE;
      endcase
    end
  end

  // Line address and pass counting over line one
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      addr_q <= PFC_FIRST_LINE;
      home_seen_q <= 2'h0;
      o_form_step <= 1'b0;
    end else begin
      o_form_step <= step;
      if (state_q == PFC_IDLE) begin
        home_seen_q <= 2'h0;
      end
      if (step) begin
        addr_q <= next_addr;
        if (next_addr == PFC_FIRST_LINE && home_seen_q != 2'h2) begin
          home_seen_q <= home_seen_q + 2'h1;
        end
      end
    end
  end

  // Image load, with end-of-form and code checks
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      load_idx_q <= 8'h00;
      load_eof_q <= 1'b0;
      load_bad_q <= 1'b0;
      eight_lpi_q <= 1'b0;
      last_line_q <= 8'(LINES - 1);
    end else if (state_q == PFC_IDLE) begin
      load_idx_q <= 8'h00;
      load_eof_q <= 1'b0;
      load_bad_q <= 1'b0;
    end else if (state_q == PFC_LOADING && i_load_valid) begin
      spacing_mem[load_idx_q] <= i_load_entry;
      load_idx_q <= load_idx_q + 8'h01;
      load_bad_q <= load_bad_q | bad_code;
      if (i_load_entry.end_of_form && !load_eof_q) begin
        load_eof_q <= 1'b1;
        last_line_q <= load_idx_q;
      end
      if (load_idx_q == PFC_FIRST_LINE) begin
        eight_lpi_q <= i_load_entry.eight_lpi;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sense bytes; hardware set wins over host clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hold_q <= 1'b0;
      for (int i = 0; i < PFC_SENSE_BYTES; i++) begin
        sense_q[i] <= 8'h00;
      end
    end else begin
      if (i_sense_clear) begin
        hold_q <= 1'b0;
        for (int i = 0; i < PFC_SENSE_BYTES; i++) begin
          sense_q[i] <= 8'h00;
        end
      end
      if (i_plb_parity_err) begin
        hold_q <= 1'b1;
        sense_q[0][PFC_SNS_PARITY] <= 1'b1;
        sense_q[0][PFC_SNS_RETRY] <= 1'b1;
      end
      if (i_plb_fault) begin
        sense_q[0][PFC_SNS_PLB_FAULT] <= 1'b1;
      end
      if (step && is_skip_q && runaway && !hit) begin
        sense_q[0][PFC_SNS_RUNAWAY] <= 1'b1;
      end
      if (state_q == PFC_LOADING && i_load_valid
          && (i_load_last || load_idx_q == 8'(LINES - 1))) begin
        sense_q[0][PFC_SNS_EOF_MISSING] <= !(load_eof_q || i_load_entry.end_of_form);
        sense_q[0][PFC_SNS_BAD_CODE] <= load_bad_q | bad_code;
      end
      sense_q[1] <= {1'b0, addr_q[6:0]};
      sense_q[2] <= {4'h0, target_q};
    end
  end

  // Flatten sense bytes, byte 0 in the low lane
  generate
    for (genvar g = 0; g < PFC_SENSE_BYTES; g++) begin : g_sense
      assign o_sense[8*g +: 8] = sense_q[g];
    end
  endgenerate
endmodule // pfc_carriage

// ==== core/pfc_pkg.sv ====
package pfc_pkg;
  // Buffer geometry
  localparam int unsigned PFC_LINES = 180;
  localparam int unsigned PFC_ADDR_W = 8;
  localparam int unsigned PFC_CODE_W = 4;
  localparam logic [3:0] PFC_CODE_MIN = 4'h1;
  localparam logic [3:0] PFC_CODE_MAX = 4'hc;
  localparam logic [7:0] PFC_FIRST_LINE = 8'h00;
  // Print line buffer positions
  localparam int unsigned PFC_POS_STD = 132;
  localparam int unsigned PFC_POS_EXT = 150;
  // Sense status
  localparam int unsigned PFC_SENSE_BYTES = 6;
  localparam int unsigned PFC_SNS_EOF_MISSING = 0;
  localparam int unsigned PFC_SNS_BAD_CODE = 1;
  localparam int unsigned PFC_SNS_PARITY = 2;
  localparam int unsigned PFC_SNS_RUNAWAY = 3;
  localparam int unsigned PFC_SNS_RETRY = 4;
  localparam int unsigned PFC_SNS_PLB_FAULT = 5;
  // One spacing buffer entry: code 0 means no stop code
  typedef struct packed {
    logic eight_lpi;
    logic end_of_form;
    logic [3:0] stop_code;
  } pfc_entry_t;
  // Host command carrier
  typedef enum logic [1:0] {
    PFC_CMD_SPACE,
    PFC_CMD_SKIP,
    PFC_CMD_LOAD
  } pfc_cmd_t;
  typedef struct packed {
    pfc_cmd_t op;
    logic [3:0] code;
    logic [7:0] count;
  } pfc_req_t;
endpackage

// ==== dv/pfc_carriage_sva.sv ====
`timescale 1ns/100ps
module pfc_carriage_sva
  import pfc_pkg::*;
#(
  parameter int unsigned LINES = PFC_LINES,
  parameter bit EXT_POSITIONS = 1'b0
) (
  input wire logic i_mclk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_req_valid, // Command offered
  input wire pfc_req_t i_req, // Command fields
  input wire logic o_req_ready, // Command ready
  input wire logic i_plb_parity_err, // Parity fault
  input wire logic i_plb_fault, // Malfunction
  input wire logic o_form_step, // Step pulse
  input wire logic [7:0] o_line_addr, // Line address
  input wire logic o_busy, // Busy
  input wire logic [8*PFC_SENSE_BYTES-1:0] o_sense, // Sense bytes
  input wire logic [7:0] o_print_positions // Line width
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  //////////////////////////////////////////////////////////////////////
  // Address stays inside the buffer
  property p_addr; o_line_addr < LINES; endproperty
  a_addr: assert property (p_addr) else $error("line address out of range");
  // Each step moves one line or wraps to line one
  property p_step;
    o_form_step |-> (o_line_addr == $past(o_line_addr) + 8'h01) || (o_line_addr == 8'h00);
  endproperty
  a_step: assert property (p_step) else $error("step did not advance one line");
  property p_skip; i_req_valid && o_req_ready && i_req.op == PFC_CMD_SKIP |=> o_busy; endproperty
  a_skip: assert property (p_skip) else $error("skip not started");
  // Two cycles of hold so a step already launched may land
  property p_hold; o_sense[4] [*2] |-> !o_form_step; endproperty
  a_hold: assert property (p_hold) else $error("motion during retry hold");
  property p_par; i_plb_parity_err |=> o_sense[2] && o_sense[4]; endproperty
  a_par: assert property (p_par) else $error("parity not flagged");
  property p_flt; i_plb_fault |=> o_sense[5]; endproperty
  a_flt: assert property (p_flt) else $error("fault not flagged");
  property p_zero; o_sense[47:24] == 24'h000000; endproperty
  a_zero: assert property (p_zero) else $error("spare sense bytes not zero");
  // Width follows the build option, not a fixed figure
  property p_pos; o_print_positions == 8'(EXT_POSITIONS ? PFC_POS_EXT : PFC_POS_STD); endproperty
  a_pos: assert property (p_pos) else $error("print width wrong");
endmodule // pfc_carriage_sva
bind pfc_carriage pfc_carriage_sva #(.LINES(LINES), .EXT_POSITIONS(EXT_POSITIONS))
  u_chk (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .i_plb_parity_err(i_plb_parity_err), .i_plb_fault(i_plb_fault), .o_form_step(o_form_step),
  .o_line_addr(o_line_addr), .o_busy(o_busy), .o_sense(o_sense),
  .o_print_positions(o_print_positions));

// ==== dv/pfc_host.sv ====
`timescale 1ns/100ps
module pfc_host
  import pfc_pkg::*;
(
  input wire logic i_mclk, // Clock
  input wire logic i_rdy, // Command ready
  input wire logic i_lrdy, // Image ready
  input wire logic i_done, // Command done
  output logic o_v = 1'b0, // Command valid
  output pfc_req_t o_req = '0, // Command
  output logic o_lv = 1'b0, // Image valid
  output pfc_entry_t o_le = '0, // Image entry
  output logic o_ll = 1'b0 // Last entry
);
  // Completions that never came inside the wait limit
  int misses = 0;
  // Held from a fall to the edge that takes it; released fields inverted
  task automatic cmd(input pfc_cmd_t op, input logic [3:0] c, input logic [7:0] n);
    @(negedge i_mclk);
    o_req = '{op, c, n};
    o_v = 1'b1;
    while (!i_rdy) @(negedge i_mclk);
    @(posedge i_mclk);
    @(negedge i_mclk);
    o_v = 1'b0;
    o_req = ~o_req;
  endtask
  // Bounded wait, one spare fall so step counts settle
  task automatic wdone;
    for (int k = 0; k < 60 && i_done !== 1'b1; k++) @(negedge i_mclk);
    if (i_done !== 1'b1) misses++;
    @(negedge i_mclk);
  endtask
  // Spacing image streamed from entry zero upward
  task automatic load(input pfc_entry_t e [8], input int n);
    cmd(PFC_CMD_LOAD, 4'h0, 8'h00);
    for (int i = 0; i < n; i++) begin
      o_le = e[i];
      o_ll = (i == n - 1);
      o_lv = 1'b1;
      while (!i_lrdy) @(negedge i_mclk);
      @(posedge i_mclk);
      @(negedge i_mclk);
    end
    o_lv = 1'b0;
    o_le = ~o_le;
    o_ll = ~o_ll;
    wdone();
  endtask
endmodule // pfc_host

// ==== dv/test_pfc_carriage.sv ====
`timescale 1ns/100ps
module test_pfc_carriage;
  import pfc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic par = 1'b0;
  logic flt = 1'b0;
  logic clr = 1'b0;
  logic v, rdy, lv, ll, lrdy, step, lpi, busy, done;
  pfc_req_t req;
  pfc_entry_t le;
  pfc_entry_t img [8];
  logic [7:0] addr, ppos;
  logic [47:0] sense;
  int bad_count = 0;
  int checks = 0;
  int steps = 0;
  always #10 i_mclk = ~i_mclk;
  always @(negedge i_mclk) if (step === 1'b1) steps++;
  pfc_host i_host (.i_mclk(i_mclk), .i_rdy(rdy), .i_lrdy(lrdy), .i_done(done), .o_v(v),
    .o_req(req), .o_lv(lv), .o_le(le), .o_ll(ll));
  pfc_carriage i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req_valid(v), .i_req(req),
    .o_req_ready(rdy), .i_load_valid(lv), .i_load_entry(le), .i_load_last(ll),
    .o_load_ready(lrdy), .i_plb_parity_err(par), .i_plb_fault(flt), .i_sense_clear(clr),
    .o_form_step(step), .o_eight_lpi(lpi), .o_line_addr(addr), .o_busy(busy), .o_done(done),
    .o_sense(sense), .o_print_positions(ppos));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic run(input pfc_cmd_t op, input logic [3:0] c, input logic [7:0] n);
    steps = 0;
    i_host.cmd(op, c, n);
    i_host.wdone();
  endtask
  task automatic pulse_clr;
    @(negedge i_mclk);
    clr = 1'b1;
    @(negedge i_mclk);
    clr = 1'b0;
  endtask
  task automatic summarize;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles of the run
  initial begin
    #200us;
    bad_count++;
    summarize();
  end
  // Eight-line form at eight lpi, stop code five on line four
  initial begin
    foreach (img[i]) img[i] = '0;
    img[0].eight_lpi = 1'b1;
    img[3].stop_code = 4'h5;
    img[7].end_of_form = 1'b1;
    repeat (20) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    chk("addr", addr, 0);
    chk("sense", sense, 0);
    i_host.load(img, 8);
    chk("lpi", lpi, 1);
    chk("ld_err", sense[1:0], 0);
    run(PFC_CMD_SPACE, 4'h0, 8'h02);
    chk("addr", addr, 2);
    chk("steps", steps, 2);
    chk("sns_line", sense[15:8], 2);
    run(PFC_CMD_SKIP, 4'h5, 8'h00);
    chk("addr", addr, 3);
    chk("sns_code", sense[23:16], 5);
    run(PFC_CMD_SKIP, 4'h5, 8'h00);
    chk("addr", addr, 3);
    chk("steps", steps, 8);
    run(PFC_CMD_SKIP, 4'h7, 8'h00);
    chk("addr", addr, 0);
    chk("steps", steps, 13);
    chk("runaway", sense[3], 1);
    pulse_clr();
    // Byte two keeps showing the last skip target after a clear
    chk("sense", sense, 48'h000000070000);
    // Retry hold must freeze a space until sense is cleared
    @(negedge i_mclk);
    par = 1'b1;
    @(negedge i_mclk);
    par = 1'b0;
    steps = 0;
    i_host.cmd(PFC_CMD_SPACE, 4'h0, 8'h01);
    repeat (10) @(negedge i_mclk);
    chk("steps", steps, 0);
    chk("retry", sense[4], 1);
    chk("parity", sense[2], 1);
    pulse_clr();
    i_host.wdone();
    chk("addr", addr, 1);
    img[7].end_of_form = 1'b0;
    img[3].stop_code = 4'hd;
    img[0].eight_lpi = 1'b0;
    i_host.load(img, 8);
    chk("ld_err", sense[1:0], 3);
    chk("lpi", lpi, 0);
    @(negedge i_mclk);
    flt = 1'b1;
    @(negedge i_mclk);
    flt = 1'b0;
    @(negedge i_mclk);
    chk("fault", sense[5], 1);
    chk("width", ppos, 8'h84);
    chk("done", i_host.misses, 0);
    summarize();
  end
endmodule // test_pfc_carriage
